/* File: hw/lsl_lane_ctrl.v */
// lsl_lane_ctrl.v: low-speed lane drive and rate register bank, four lanes
// assumes: single-cycle strobes, read data one cycle later, power-down pin asynchronous
// What this block does
// RQ1: register at 0x07, resets to 0xDC04
// RQ2: bit 15 reserved read/write, resets one
// RQ3: bits 14:12 output amplitude, default 101
// RQ4: bit 11 enables loss-of-signal detection
// RQ5: bit 10 enables input lane, default one
// RQ6: power-down pin or global bit forces inputs off
// RQ7: two-to-one mode forces input lanes 3,2 off
// RQ8: bits 9:8 input lane rate code
// RQ9: bits 7:4 output de-emphasis code, default 0
// RQ10: bit 3 reserved read/write, resets zero
// RQ11: bit 2 enables output lane, default one
// RQ12: power-down pin or global bit forces outputs off
// RQ13: one-to-two mode forces output lanes 3,2 off
// RQ14: bits 1:0 output lane rate code
// RQ15: reads return the OR of the settings of every selected lane
// RQ16: writes update every selected lane
`timescale 1ns/10ps
`include "lsl_map.vh"
module lsl_lane_ctrl #(
   parameter LANES = 4,
   parameter W = 16
) (
   // clock and reset
   input wire i_sys_clk,
   input wire i_nrst,
   // register port
   input wire [`LSL_ADDR_W-1:0] i_addr,
   input wire [W-1:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output wire [W-1:0] o_rdata,
   // pin
   input wire i_channel_power_down_n,
   // per-lane controls
   output wire [LANES*3-1:0] o_output_amplitude_code,
   output wire [LANES-1:0] o_signal_loss_detect_enable,
   output wire [LANES-1:0] o_input_lane_on,
   output wire [LANES*2-1:0] o_input_lane_rate_code,
   output wire [LANES*4-1:0] o_output_deemphasis_code,
   output wire [LANES-1:0] o_output_lane_on,
   output wire [LANES*2-1:0] o_output_lane_rate_code
);
   // register state
   reg [LANES-1:0] lane_sel_q;
   reg [LANES-1:0] lane_sel_d;
   reg [2:0] global_q;
   reg [2:0] global_d;
   reg [W-1:0] rdata_q;
   reg [W-1:0] rdata_d;

   // address decode
   wire hit_drive_rate;
   wire hit_lane_sel;
   wire hit_global;
   wire hit_status;
   wire wr_drive_rate;
   wire wr_lane_sel;
   wire wr_global;

   // power-down and lane modes
   wire pd_n_s;
   wire pin_pd;
   wire glob_pd;
   wire mode_2to1;
   wire mode_1to2;
   wire force_off;

   // per-lane collections
   wire [LANES*W-1:0] words;
   wire [(LANES+1)*W-1:0] sel_or;
   wire [LANES-1:0] in_on;
   wire [LANES-1:0] out_on;

   // read-back words
   wire [W-1:0] rd_drive_rate;
   wire [W-1:0] rd_lane_sel;
   wire [W-1:0] rd_global;
   wire [W-1:0] rd_status;

   assign hit_drive_rate = (i_addr == `LSL_OFF_DRIVE_RATE);
   assign hit_lane_sel = (i_addr == `LSL_OFF_LANE_SEL);
   assign hit_global = (i_addr == `LSL_OFF_GLOBAL);
   assign hit_status = (i_addr == `LSL_OFF_STATUS);
   assign wr_drive_rate = i_wr & hit_drive_rate;
   assign wr_lane_sel = i_wr & hit_lane_sel;
   assign wr_global = i_wr & hit_global;

   // pin level resynchronised before it gates any lane
   lsl_sync2 #(.RST_VAL(1'b1)) u_pd_sync (
      .i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_d(i_channel_power_down_n),
      .o_q(pd_n_s)
   );

   assign pin_pd = ~pd_n_s;
   assign glob_pd = global_q[`LSL_GBIT_PD];
   assign mode_2to1 = global_q[`LSL_GBIT_2TO1];
   assign mode_1to2 = global_q[`LSL_GBIT_1TO2];

   // RQ6 RQ12 power-down override
   assign force_off = pin_pd | glob_pd;

   // lane select: written only at its own offset
   always @* begin
      lane_sel_d = lane_sel_q;
      if (wr_lane_sel) begin
         lane_sel_d = i_wdata[LANES-1:0];
      end
   end

   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         lane_sel_q <= `LSL_RST_LANE_SEL;
      end else begin
         lane_sel_q <= lane_sel_d;
      end
   end

   // global word: power-down and lane modes
   always @* begin
      global_d = global_q;
      if (wr_global) begin
         global_d = i_wdata[2:0];
      end
   end

   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         global_q <= `LSL_RST_GLOBAL;
      end else begin
         global_q <= global_d;
      end
   end

   // the read word is built up lane by lane from an all-zero seed
   assign sel_or[W-1:0] = {W{1'b0}};

   genvar g;
   generate
      for (g = 0; g < LANES; g = g + 1) begin : g_lane
         wire [W-1:0] w;
         wire lane_wr;
         wire [2:0] amp;
         wire los;
         wire [1:0] irate;
         wire [3:0] de;
         wire [1:0] orate;
         wire hi_lane;
         wire in_en;
         wire out_en;
         wire in_block;
         wire out_block;
         reg in_on_q;
         reg out_on_q;

         // RQ1 RQ16 selected lanes written
         assign lane_wr = wr_drive_rate & lane_sel_q[g];
         lsl_lane_store #(.W(W)) u_store (
            .i_sys_clk(i_sys_clk),
            .i_nrst(i_nrst),
            .i_wr(lane_wr),
            .i_wdata(i_wdata),
            .o_word(w)
         );
         assign words[g*W +: W] = w;

         // RQ3 RQ9 drive codes
         assign amp = w[`LSL_AMP_HI:`LSL_AMP_LO];
         assign de = w[`LSL_DE_HI:`LSL_DE_LO];
         assign o_output_amplitude_code[g*3 +: 3] = amp;
         assign o_output_deemphasis_code[g*4 +: 4] = de;

         // RQ4 loss detect enable
         assign los = w[`LSL_BIT_LOS];
         assign o_signal_loss_detect_enable[g] = los;

         // RQ8 RQ14 rate codes
         assign irate = w[`LSL_IRATE_HI:`LSL_IRATE_LO];
         assign orate = w[`LSL_ORATE_HI:`LSL_ORATE_LO];
         assign o_input_lane_rate_code[g*2 +: 2] = irate;
         assign o_output_lane_rate_code[g*2 +: 2] = orate;

         // RQ5 RQ11 stored enables
         assign in_en = w[`LSL_BIT_IN_EN];
         assign out_en = w[`LSL_BIT_OUT_EN];

         // lanes 3 and 2 are the pair dropped in the narrow modes
         assign hi_lane = (g >= 2) ? 1'b1 : 1'b0;
         // RQ7 RQ13 narrow-mode lane drop
         assign in_block = force_off | (mode_2to1 & hi_lane);
         assign out_block = force_off | (mode_1to2 & hi_lane);

         // effective input enable, one register stage after its cause
         always @(posedge i_sys_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               in_on_q <= 1'b0;
            end else begin
               in_on_q <= in_en & ~in_block;
            end
         end

         // effective output enable, one register stage after its cause
         always @(posedge i_sys_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               out_on_q <= 1'b0;
            end else begin
               out_on_q <= out_en & ~out_block;
            end
         end
         assign in_on[g] = in_on_q;
         assign out_on[g] = out_on_q;

         // RQ15 selected lane joins the read word
         assign sel_or[(g+1)*W +: W] = sel_or[g*W +: W] | (lane_sel_q[g] ? w : {W{1'b0}});
      end
   endgenerate

   assign o_input_lane_on = in_on;
   assign o_output_lane_on = out_on;

   // RQ2 RQ10 reserved bits read back as stored
   assign rd_drive_rate = sel_or[LANES*W +: W];
   assign rd_lane_sel = {{(W-LANES){1'b0}}, lane_sel_q};
   assign rd_global = {{(W-3){1'b0}}, global_q};
   assign rd_status = {{(W-2*LANES-1){1'b0}}, pin_pd, out_on, in_on};

   // RQ15 read mux, unmapped offsets read zero
   always @* begin
      rdata_d = {W{1'b0}};
      if (hit_drive_rate) begin
         rdata_d = rd_drive_rate;
      end else if (hit_lane_sel) begin
         rdata_d = rd_lane_sel;
      end else if (hit_global) begin
         rdata_d = rd_global;
      end else if (hit_status) begin
         rdata_d = rd_status;
      end
   end

   // read data stand for one cycle only, zero otherwise
   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rdata_q <= {W{1'b0}};
      end else if (i_rd) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= {W{1'b0}};
      end
   end
   assign o_rdata = rdata_q;
endmodule // lsl_lane_ctrl

/* File: hw/lsl_lane_store.v */
// lsl_lane_store.v: one lane's 16-bit settings word, written when selected
// assumes: clock and reset shared with the register bank
`timescale 1ns/10ps
`include "lsl_map.vh"
module lsl_lane_store #(
   parameter W = 16
) (
   // clock and reset
   input wire i_sys_clk,
   input wire i_nrst,
   // write port
   input wire i_wr,
   input wire [W-1:0] i_wdata,
   // stored word
   output wire [W-1:0] o_word
);
   reg [W-1:0] word_q;
   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         word_q <= `LSL_RST_DRIVE_RATE;
      end else if (i_wr) begin
         word_q <= i_wdata;
      end
   end
   assign o_word = word_q;
endmodule // lsl_lane_store

/* File: hw/lsl_map.vh */
// lsl_map.vh: offsets, field positions, reset values for the lane control register
// assumes: included by the lane control design files only
`ifndef LSL_MAP_VH
`define LSL_MAP_VH
`define LSL_ADDR_W 5
`define LSL_OFF_DRIVE_RATE 5'h07
`define LSL_OFF_LANE_SEL 5'h10
`define LSL_OFF_GLOBAL 5'h11
`define LSL_OFF_STATUS 5'h12
`define LSL_RST_DRIVE_RATE 16'hDC04
`define LSL_RST_LANE_SEL 4'h1
`define LSL_RST_GLOBAL 3'h0
`define LSL_BIT_RSVD_HI 15
`define LSL_AMP_HI 14
`define LSL_AMP_LO 12
`define LSL_BIT_LOS 11
`define LSL_BIT_IN_EN 10
`define LSL_IRATE_HI 9
`define LSL_IRATE_LO 8
`define LSL_DE_HI 7
`define LSL_DE_LO 4
`define LSL_BIT_RSVD_LO 3
`define LSL_BIT_OUT_EN 2
`define LSL_ORATE_HI 1
`define LSL_ORATE_LO 0
`define LSL_GBIT_PD 0
`define LSL_GBIT_2TO1 1
`define LSL_GBIT_1TO2 2
`endif

/* File: hw/lsl_sync2.v */
// lsl_sync2.v: two flip-flop synchroniser for a pin level
// assumes: input is asynchronous to i_sys_clk
`timescale 1ns/10ps
module lsl_sync2 #(
   parameter RST_VAL = 1'b1
) (
   // clock and reset
   input wire i_sys_clk,
   input wire i_nrst,
   // level in and out
   input wire i_d,
   output wire o_q
);
   reg s1_q;
   reg s2_q;
   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
      end else begin
         s1_q <= i_d;
         s2_q <= s1_q;
      end
   end
   assign o_q = s2_q;
endmodule // lsl_sync2

/* File: sim/lsl_lane_ctrl_props.sv */
// lsl_lane_ctrl_props.sv: port checks for the lane control bank
// assumes: bound to lsl_lane_ctrl, select and global words tracked here
`timescale 1ns/10ps
module lsl_lane_ctrl_props #(parameter LANES = 4, parameter W = 16) (
   input wire i_sys_clk, input wire i_nrst, input wire [4:0] i_addr,
   input wire [W-1:0] i_wdata, input wire i_wr, input wire i_rd, input wire [W-1:0] o_rdata,
   input wire i_channel_power_down_n, input wire [LANES*3-1:0] o_output_amplitude_code,
   input wire [LANES-1:0] o_signal_loss_detect_enable, o_input_lane_on, o_output_lane_on,
   input wire [LANES*2-1:0] o_input_lane_rate_code, o_output_lane_rate_code,
   input wire [LANES*4-1:0] o_output_deemphasis_code
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   reg [3:0] sel_q;
   reg [2:0] g_q;
   wire rd_l0 = i_rd && i_addr == 5'h07 && sel_q == 4'h1;
   wire rd_bad = i_rd && i_addr != 5'h07 && !(i_addr[4:2] == 3'b100 && i_addr[1:0] != 2'b11);
   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sel_q <= 4'h1;
         g_q <= 3'h0;
      end else if (i_wr && i_addr == 5'h10) sel_q <= i_wdata[3:0];
      else if (i_wr && i_addr == 5'h11) g_q <= i_wdata[2:0];
   end
   sequence pin_low_run;
      !i_channel_power_down_n [*4];
   endsequence
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
      else $error("read data not idle");
   a_unmapped_zero: assert property ($past(rd_bad) |-> o_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_read_lane0: assert property ($past(rd_l0) |-> o_rdata[14:12] == o_output_amplitude_code[2:0]
      && o_rdata[11] == o_signal_loss_detect_enable[0] && o_rdata[9:8] == o_input_lane_rate_code[1:0]
      && o_rdata[7:4] == o_output_deemphasis_code[3:0] && o_rdata[1:0] == o_output_lane_rate_code[1:0])
      else $error("lane read differs from lane outputs");
   a_pin_off: assert property (pin_low_run |-> o_input_lane_on == 4'h0 && o_output_lane_on == 4'h0)
      else $error("lanes on while pin low");
   a_global_off: assert property (g_q[0] && $past(g_q[0]) |-> (o_input_lane_on | o_output_lane_on) == 4'h0)
      else $error("lanes on in global power-down");
   a_two_to_one: assert property (g_q[1] && $past(g_q[1]) |-> o_input_lane_on[3:2] == 2'b00)
      else $error("input lanes 3,2 on");
   a_one_to_two: assert property (g_q[2] && $past(g_q[2]) |-> o_output_lane_on[3:2] == 2'b00)
      else $error("output lanes 3,2 on");
   a_codes_hold: assert property (!$past(i_wr) |-> $stable(o_output_deemphasis_code))
      else $error("codes moved without write");
   a_drive_hold: assert property (!$past(i_wr) |-> $stable(o_output_amplitude_code)
      && $stable(o_signal_loss_detect_enable) && $stable(o_input_lane_rate_code)
      && $stable(o_output_lane_rate_code))
      else $error("drive or rate codes moved without write");
endmodule // lsl_lane_ctrl_props
bind lsl_lane_ctrl lsl_lane_ctrl_props #(.LANES(LANES), .W(W)) lsl_lane_ctrl_props_i (
   .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .i_channel_power_down_n(i_channel_power_down_n),
   .o_output_amplitude_code(o_output_amplitude_code),
   .o_signal_loss_detect_enable(o_signal_loss_detect_enable),
   .o_input_lane_on(o_input_lane_on), .o_output_lane_on(o_output_lane_on),
   .o_input_lane_rate_code(o_input_lane_rate_code),
   .o_output_lane_rate_code(o_output_lane_rate_code),
   .o_output_deemphasis_code(o_output_deemphasis_code)
);

/* File: sim/lsl_lane_ctrl_tb.sv */
// lsl_lane_ctrl_tb.sv: register bus tests for the lane control bank
// assumes: 20 MHz clock, checker bound in its own file
`timescale 1ns/10ps
module lsl_lane_ctrl_tb;
   reg i_sys_clk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_channel_power_down_n = 1'b1;
   reg [4:0] i_addr = 5'h00;
   reg [15:0] i_wdata = 16'h0000;
   wire [15:0] o_rdata, o_output_deemphasis_code;
   wire [11:0] o_output_amplitude_code;
   wire [3:0] o_signal_loss_detect_enable, o_input_lane_on, o_output_lane_on;
   wire [7:0] o_input_lane_rate_code, o_output_lane_rate_code;
   integer n_fail = 0, check_count = 0, k;
   always #25 i_sys_clk = ~i_sys_clk;
   lsl_lane_ctrl lsl_lane_ctrl_i (
      .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_channel_power_down_n(i_channel_power_down_n),
      .o_output_amplitude_code(o_output_amplitude_code),
      .o_signal_loss_detect_enable(o_signal_loss_detect_enable),
      .o_input_lane_on(o_input_lane_on),
      .o_input_lane_rate_code(o_input_lane_rate_code),
      .o_output_deemphasis_code(o_output_deemphasis_code),
      .o_output_lane_on(o_output_lane_on),
      .o_output_lane_rate_code(o_output_lane_rate_code)
   );
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task acc(input w, input [4:0] a, input [15:0] d);
      begin
         @(posedge i_sys_clk);
         i_wr <= w;
         i_rd <= !w;
         i_addr <= a;
         i_wdata <= d;
         @(posedge i_sys_clk);
         i_wr <= 1'b0;
         i_rd <= 1'b0;
         #1 if (!w) chk(o_rdata, d);
      end
   endtask
   task settle;
      begin
         repeat (3) @(posedge i_sys_clk);
         #1;
      end
   endtask
   task gm(input [15:0] m, input [7:0] exp);
      begin
         acc(1, 5'h11, m);
         settle;
         chk({o_input_lane_on, o_output_lane_on}, exp);
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", check_count, n_fail);
         if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   initial begin
      #200000 n_fail = n_fail + 1;
      wrap_up;
   end
   initial begin
      repeat (10) @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      settle;
      acc(0, 5'h07, 16'hDC04);
      chk({o_output_amplitude_code, o_signal_loss_detect_enable}, 16'hB6DF);
      chk({o_input_lane_on, o_output_lane_on, o_input_lane_rate_code}, 16'hFF00);
      for (k = 0; k < 4; k = k + 1) begin
         acc(1, 5'h07, 16'hDC04 | {6'h00, k[1:0], 6'h00, k[1:0]});
         settle;
         chk({o_input_lane_rate_code[1:0], o_output_lane_rate_code[1:0]}, {k[1:0], k[1:0]});
      end
      acc(1, 5'h10, 16'h000F);
      acc(0, 5'h10, 16'h000F);
      acc(1, 5'h07, 16'h1234);
      acc(1, 5'h10, 16'h0002);
      acc(1, 5'h07, 16'h7FF8);
      acc(1, 5'h1F, 16'h0000);
      acc(0, 5'h1F, 16'h0000);
      for (k = 0; k < 4; k = k + 1) begin
         acc(1, 5'h10, 16'h0001 << k);
         acc(0, 5'h07, k == 1 ? 16'h7FF8 : 16'h1234);
      end
      chk(o_output_deemphasis_code, 16'h33F3);
      chk({o_output_amplitude_code, o_signal_loss_detect_enable}, 16'h2792);
      chk({o_input_lane_on, o_output_lane_on}, 8'h2D);
      acc(1, 5'h10, 16'h000F);
      acc(1, 5'h07, 16'hDC04);
      gm(16'h0002, 8'h3F);
      gm(16'h0004, 8'hF3);
      acc(0, 5'h11, 16'h0004);
      acc(0, 5'h12, 16'h003F);
      gm(16'h0001, 8'h00);
      gm(16'h0000, 8'hFF);
      @(posedge i_sys_clk);
      i_channel_power_down_n <= 1'b0;
      settle;
      chk({o_input_lane_on, o_output_lane_on}, 8'h00);
      acc(0, 5'h12, 16'h0100);
      @(posedge i_sys_clk);
      i_channel_power_down_n <= 1'b1;
      settle;
      chk({o_input_lane_on, o_output_lane_on}, 8'hFF);
      acc(0, 5'h12, 16'h00FF);
      wrap_up;
   end
endmodule // lsl_lane_ctrl_tb
